// ### shared/cpdf_map.svh
// Byte positions, record sizes and codes for the cyclic telegram
`ifndef CPDF_MAP_SVH
`define CPDF_MAP_SVH
`define CPDF_REC_BYTES      5
`define CPDF_VAL_BYTES      4
`define CPDF_NUM_REC        4
`define CPDF_IN_BYTES       20
`define CPDF_OUT_BYTES      8
`define CPDF_STAT_POS       4
`define CPDF_IDX_W          5
`define CPDF_OUT_TOT_SET    0
`define CPDF_OUT_TOT_MODE   1
`define CPDF_OUT_DISP_VAL   2
`define CPDF_OUT_DISP_STAT  6
`define CPDF_OUT_CTRL       7
`define CPDF_BYTE_ZERO      8'h00
`define CPDF_TOT_HOLD       8'h03
`define CPDF_TOT_RESET      8'h01
`endif

// ### shared/cpdf_pkg.sv
// Types shared by both ends of the cyclic process data link
package cpdf_pkg;
    typedef logic [7:0]  cpdf_byte_t;
    typedef logic [31:0] cpdf_float_t;
    typedef enum logic [1:0] {
        CPDF_REC_VOL_FLOW,
        CPDF_REC_SOUND_VEL,
        CPDF_REC_FLOW_VEL,
        CPDF_REC_TOTAL
    } cpdf_rec_e;
    typedef struct packed {
        cpdf_float_t value;
        cpdf_byte_t  status;
    } cpdf_rec_s;
endpackage

// ### shared/cpdf_link_if.sv
// Byte-serial cyclic exchange between device and cyclic master
`timescale 1ns/100ps
interface cpdf_link_if;
    import cpdf_pkg::*;
    logic       in_start;
    logic       in_valid;
    logic       in_last;
    cpdf_byte_t in_data;
    logic       in_ready;
    logic       out_valid;
    logic       out_last;
    cpdf_byte_t out_data;
    logic       out_ready;
    modport dev (
        output in_start,
        output in_valid,
        output in_last,
        output in_data,
        input  in_ready,
        input  out_valid,
        input  out_last,
        input  out_data,
        output out_ready
    );
    modport mst (
        input  in_start,
        input  in_valid,
        input  in_last,
        input  in_data,
        output in_ready,
        output out_valid,
        output out_last,
        output out_data,
        input  out_ready
    );
endinterface

// ### src/cpdf_device.sv
// Device end: builds the 20-byte input telegram, takes the output telegram
// Notes on behaviour
// - Each analog record is exactly five bytes
// - Leading four bytes carry IEEE-754 single float
// - Fifth byte is the profile status byte
// - Local display shows the transmitted status; the code shows the latched rec_r status, not the frame snapshot
// - Sign, exponent, mantissa sent most significant byte first
// - Device delivers records; master reads them cyclically
// - Order: volume, sound velocity, flow velocity, totalizer
// - Master tolerates shifted absolute byte positions
// - Only these four quantities are input data
// - Totalizer travels with its control bytes
// - Totalizer alone or with one/two controls; the code always takes both controls, at output bytes 0 and 1
// - Display value and control block are outputs
// - Master may blank unused records, order kept
`timescale 1ns/100ps
`include "cpdf_map.svh"
module cpdf_device #(
    parameter int NUM_REC = `CPDF_NUM_REC
) (
    input  wire logic                 clk_sys,
    input  wire logic                 rst,
    cpdf_link_if.dev                  link,
    input  wire cpdf_pkg::cpdf_rec_s  meas [NUM_REC],
    input  wire logic [NUM_REC-1:0]   meas_upd,
    input  wire logic                 cycle_go,
    output logic                      cycle_busy,
    output cpdf_pkg::cpdf_byte_t      disp_status [NUM_REC],
    output cpdf_pkg::cpdf_float_t     disp_value,
    output cpdf_pkg::cpdf_byte_t      disp_value_stat,
    output cpdf_pkg::cpdf_byte_t      tot_set,
    output cpdf_pkg::cpdf_byte_t      tot_mode,
    output logic                      tot_reset_pulse,
    output logic                      tot_hold,
    output cpdf_pkg::cpdf_byte_t      ctrl_cmd,
    output logic                      ctrl_cmd_pulse
);
    import cpdf_pkg::*;

    localparam int IN_BYTES = NUM_REC * `CPDF_REC_BYTES;

    cpdf_rec_s              rec_r [NUM_REC];
    cpdf_rec_s              snap_r [NUM_REC];
    logic [`CPDF_IDX_W-1:0] idx_r;
    logic [2:0]             sub_r;
    logic [1:0]             rec_i_r;
    logic                   start_r;
    logic [`CPDF_IDX_W-1:0] oidx_r;
    cpdf_byte_t             obuf_r [`CPDF_OUT_BYTES];
    cpdf_byte_t             set_prev_r;
    cpdf_byte_t             ctrl_prev_r;
    logic                   in_fire;
    logic                   out_fire;
    cpdf_rec_s              cur;

    // Value and status latched as one word, never apart
    for (genvar g = 0; g < NUM_REC; g++) begin : g_rec
        always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
                rec_r[g] <= '0;
            end else if (meas_upd[g]) begin
                rec_r[g] <= meas[g];
            end
        end
        // Display mirrors the latest latched status byte, not the snapshot being sent
        assign disp_status[g] = rec_r[g].status;
    end

    assign in_fire  = link.in_valid & link.in_ready;
    assign out_fire = link.out_valid & link.out_ready;
    assign cur      = snap_r[rec_i_r];

    // Frame sequencer; records snapshot at frame start
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cycle_busy <= 1'b0;
            idx_r      <= '0;
            sub_r      <= '0;
            rec_i_r    <= '0;
            start_r    <= 1'b0;
            for (int i = 0; i < NUM_REC; i++) begin
                snap_r[i] <= '0;
            end
        end else if (!cycle_busy) begin
            if (cycle_go) begin
                cycle_busy <= 1'b1;
                idx_r      <= '0;
                sub_r      <= '0;
                rec_i_r    <= '0;
                start_r    <= 1'b1;
                snap_r     <= rec_r;
            end
        end else if (in_fire) begin
            start_r <= 1'b0;
            idx_r   <= idx_r + 1'b1;
            // Five bytes per record, then next record in order
            if (sub_r == 3'(`CPDF_STAT_POS)) begin
                sub_r   <= '0;
                rec_i_r <= rec_i_r + 1'b1;
            end else begin
                sub_r <= sub_r + 1'b1;
            end
            if (idx_r == `CPDF_IDX_W'(IN_BYTES - 1)) begin
                cycle_busy <= 1'b0;
            end
        end
    end

    // Byte mux: float MSB first, then status
    always_comb begin
        link.in_data = `CPDF_BYTE_ZERO;
        case (sub_r)
            3'd0:    link.in_data = cur.value[31:24];
            3'd1:    link.in_data = cur.value[23:16];
            3'd2:    link.in_data = cur.value[15:8];
            3'd3:    link.in_data = cur.value[7:0];
            default: link.in_data = cur.status;
        endcase
    end
    assign link.in_valid = cycle_busy;
    assign link.in_start = cycle_busy & start_r;
    assign link.in_last  = cycle_busy & (idx_r == `CPDF_IDX_W'(IN_BYTES - 1));
    assign link.out_ready = 1'b1;

    // Output telegram store; short frames leave later bytes untouched
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            oidx_r <= '0;
            for (int i = 0; i < `CPDF_OUT_BYTES; i++) begin
                obuf_r[i] <= `CPDF_BYTE_ZERO;
            end
        end else if (out_fire) begin
            if (oidx_r < `CPDF_IDX_W'(`CPDF_OUT_BYTES)) begin
                obuf_r[oidx_r[2:0]] <= link.out_data;
            end
            oidx_r <= link.out_last ? '0 : oidx_r + 1'b1;
        end
    end

    // Totalizer control and display value decoded from outputs
    assign tot_set         = obuf_r[`CPDF_OUT_TOT_SET];
    assign tot_mode        = obuf_r[`CPDF_OUT_TOT_MODE];
    assign disp_value      = {obuf_r[`CPDF_OUT_DISP_VAL],
                              obuf_r[`CPDF_OUT_DISP_VAL + 1],
                              obuf_r[`CPDF_OUT_DISP_VAL + 2],
                              obuf_r[`CPDF_OUT_DISP_VAL + 3]};
    assign disp_value_stat = obuf_r[`CPDF_OUT_DISP_STAT];
    assign ctrl_cmd        = obuf_r[`CPDF_OUT_CTRL];
    assign tot_hold        = (tot_mode == `CPDF_TOT_HOLD);

    // Totalizer reset only on a change to 01h; control only on leaving zero
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            set_prev_r      <= `CPDF_BYTE_ZERO;
            ctrl_prev_r     <= `CPDF_BYTE_ZERO;
            tot_reset_pulse <= 1'b0;
            ctrl_cmd_pulse  <= 1'b0;
        end else begin
            set_prev_r      <= tot_set;
            ctrl_prev_r     <= ctrl_cmd;
            tot_reset_pulse <= (tot_set != set_prev_r) &&
                               (tot_set == `CPDF_TOT_RESET);
            ctrl_cmd_pulse  <= (ctrl_prev_r == `CPDF_BYTE_ZERO) &&
                               (ctrl_cmd != `CPDF_BYTE_ZERO);
        end
    end
endmodule

// ### src/cpdf_master.sv
// Master end: reads the input telegram, sends the output telegram
`timescale 1ns/100ps
`include "cpdf_map.svh"
module cpdf_master (
    input  wire logic                 clk_sys,
    input  wire logic                 rst,
    cpdf_link_if.mst                  link,
    output cpdf_pkg::cpdf_rec_s       rec_out [`CPDF_NUM_REC],
    output logic                      rec_done,
    input  wire cpdf_pkg::cpdf_byte_t out_bytes [`CPDF_OUT_BYTES],
    input  wire logic                 out_go,
    output logic                      out_busy
);
    import cpdf_pkg::*;

    cpdf_rec_s              asm_r [`CPDF_NUM_REC];
    logic [`CPDF_IDX_W-1:0] idx_r;
    logic [`CPDF_IDX_W-1:0] oidx_r;
    cpdf_byte_t             ohold_r [`CPDF_OUT_BYTES];
    logic                   in_fire;
    logic [`CPDF_IDX_W-1:0] pos;
    logic [1:0]             rec_w;
    logic [2:0]             sub_w;

    assign in_fire       = link.in_valid & link.in_ready;
    assign link.in_ready = 1'b1;

    // Byte position; start forces zero so a lost byte cannot skew a frame
    always_comb begin
        pos   = link.in_start ? '0 : idx_r;
        rec_w = 2'(pos / `CPDF_REC_BYTES);
        sub_w = 3'(pos % `CPDF_REC_BYTES);
    end

    // Cyclic read of input data, records in fixed order
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            idx_r    <= '0;
            rec_done <= 1'b0;
            for (int i = 0; i < `CPDF_NUM_REC; i++) begin
                asm_r[i]   <= '0;
                rec_out[i] <= '0;
            end
        end else begin
            rec_done <= 1'b0;
            if (in_fire) begin
                // Float bytes arrive most significant first, then status
                if (sub_w == 3'(`CPDF_STAT_POS)) begin
                    asm_r[rec_w].status <= link.in_data;
                end else begin
                    asm_r[rec_w].value[8*(`CPDF_VAL_BYTES-1-sub_w) +: 8]
                        <= link.in_data;
                end
                idx_r <= link.in_last ? '0 : pos + 1'b1;
                if (link.in_last) begin
                    rec_out  <= asm_r;
                    rec_out[`CPDF_NUM_REC-1].status <= link.in_data;
                    rec_done <= 1'b1;
                end
            end
        end
    end

    // Output sequencer: totalizer controls, display, control
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            out_busy <= 1'b0;
            oidx_r   <= '0;
            for (int i = 0; i < `CPDF_OUT_BYTES; i++) begin
                ohold_r[i] <= `CPDF_BYTE_ZERO;
            end
        end else if (!out_busy) begin
            if (out_go) begin
                out_busy <= 1'b1;
                oidx_r   <= '0;
                ohold_r  <= out_bytes;
            end
        end else if (link.out_ready) begin
            oidx_r <= oidx_r + 1'b1;
            if (oidx_r == `CPDF_IDX_W'(`CPDF_OUT_BYTES - 1)) begin
                out_busy <= 1'b0;
            end
        end
    end
    assign link.out_valid = out_busy;
    assign link.out_data  = ohold_r[oidx_r[2:0]];
    assign link.out_last  = out_busy &
                            (oidx_r == `CPDF_IDX_W'(`CPDF_OUT_BYTES - 1));
endmodule

// ### testbench/cpdf_link_asserts.sv
// Protocol assertions on the cyclic telegram link
`timescale 1ns/100ps
module cpdf_link_asserts (
    input wire logic                 clk_sys,
    input wire logic                 rst,
    input wire logic                 in_start,
    input wire logic                 in_valid,
    input wire logic                 in_last,
    input wire cpdf_pkg::cpdf_byte_t in_data,
    input wire logic                 in_ready,
    input wire logic                 out_valid,
    input wire logic                 out_last,
    input wire cpdf_pkg::cpdf_byte_t out_data,
    input wire logic                 out_ready
);
    import cpdf_pkg::*;
    logic [4:0] in_idx_r;
    logic [3:0] out_idx_r;
    // Input byte position; cleared on last so a lost last shows
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst)
            in_idx_r <= 5'h00;
        else if (in_valid)
            in_idx_r <= in_last ? 5'h00 : in_idx_r + 5'h01;
    end
    // Output byte position
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst)
            out_idx_r <= 4'h0;
        else if (out_valid)
            out_idx_r <= out_last ? 4'h0 : out_idx_r + 4'h1;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_head;
        in_start && in_valid;
    endsequence
    sequence s_rec;
        in_valid [*5];
    endsequence
    AST_HEAD_FIRST: assert property (in_valid && in_idx_r == 0 |-> in_start)
        else $error("first byte lacks start");
    AST_START_POS: assert property (in_start |-> in_valid && in_idx_r == 0)
        else $error("start away from byte 0");
    AST_LAST_POS: assert property (in_valid && in_last |-> in_idx_r == 19)
        else $error("input frame length wrong");
    AST_LAST_DUE: assert property (in_valid && in_idx_r == 19 |-> in_last)
        else $error("byte 19 not marked last");
    AST_REC_BODY: assert property (s_head |=> s_rec)
        else $error("first record broken");
    AST_IN_GAP: assert property (in_valid && !in_last |=> in_valid)
        else $error("gap inside input frame");
    AST_OUT_LAST: assert property (out_valid && out_last |-> out_idx_r == 7)
        else $error("output frame length wrong");
    AST_OUT_DUE: assert property (out_valid && out_idx_r == 7 |-> out_last)
        else $error("output byte 7 not last");
    AST_OUT_GAP: assert property (out_valid && !out_last |=> out_valid)
        else $error("gap inside output frame");
    AST_IN_TAKEN: assert property (in_valid |-> in_ready)
        else $error("input byte not taken");
    AST_OUT_TAKEN: assert property (out_valid |-> out_ready)
        else $error("output byte not taken");
endmodule

// ### testbench/tb_top.sv
// Bench joining device and master ends across the link
`timescale 1ns/100ps
module tb_top;
    import cpdf_pkg::*;
    logic        clk_sys, rst, cycle_go, cycle_busy, out_go, out_busy;
    logic        tot_reset_pulse, tot_hold, ctrl_cmd_pulse, rec_done;
    logic [3:0]  meas_upd;
    cpdf_rec_s   meas [4];
    cpdf_rec_s   nxt [4];
    cpdf_rec_s   rec_out [4];
    cpdf_byte_t  disp_status [4];
    cpdf_byte_t  out_bytes [8];
    cpdf_byte_t  disp_value_stat, tot_set, tot_mode, ctrl_cmd;
    cpdf_float_t disp_value;
    int          error_cnt, num_checks, n_rst, n_ctrl, k;
    cpdf_link_if link ();
    cpdf_device #(.NUM_REC(4)) cpdf_device_i (.clk_sys(clk_sys), .rst(rst),
        .link(link), .meas(meas), .meas_upd(meas_upd), .cycle_go(cycle_go),
        .cycle_busy(cycle_busy), .disp_status(disp_status),
        .disp_value(disp_value), .disp_value_stat(disp_value_stat),
        .tot_set(tot_set), .tot_mode(tot_mode), .tot_hold(tot_hold),
        .tot_reset_pulse(tot_reset_pulse), .ctrl_cmd(ctrl_cmd),
        .ctrl_cmd_pulse(ctrl_cmd_pulse));
    cpdf_master cpdf_master_i (.clk_sys(clk_sys), .rst(rst), .link(link),
        .rec_out(rec_out), .rec_done(rec_done), .out_bytes(out_bytes),
        .out_go(out_go), .out_busy(out_busy));
    cpdf_link_asserts cpdf_link_asserts_i (.clk_sys(clk_sys), .rst(rst),
        .in_start(link.in_start), .in_valid(link.in_valid),
        .in_last(link.in_last), .in_data(link.in_data),
        .in_ready(link.in_ready), .out_valid(link.out_valid),
        .out_last(link.out_last), .out_data(link.out_data),
        .out_ready(link.out_ready));
    // 250 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    // Count one-cycle pulses so a stuck or doubled pulse shows
    always @(posedge clk_sys) begin
        if (tot_reset_pulse === 1'b1)
            n_rst++;
        if (ctrl_cmd_pulse === 1'b1)
            n_ctrl++;
    end
    task chk(input string nm, input logic [63:0] s, input logic [63:0] e);
        num_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("unexpected %s exp %h seen %h", nm, e, s);
        end
    endtask
    task end_sim;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task load;
        @(posedge clk_sys);
        for (k = 0; k < 4; k++)
            meas[k] <= nxt[k];
        meas_upd <= 4'hF;
        @(posedge clk_sys);
        meas_upd <= 4'h0;
    endtask
    task go;
        @(posedge clk_sys);
        cycle_go <= 1'b1;
        @(posedge clk_sys);
        cycle_go <= 1'b0;
    endtask
    // Read one frame off the wire; poke marks inputs changed mid-frame
    task frame(input logic [159:0] e, input bit poke);
        int i;
        i = 0;
        @(negedge clk_sys);
        while (link.in_valid !== 1'b1 && i < 10) begin
            @(negedge clk_sys);
            i++;
        end
        for (i = 0; i < 20; i++) begin
            chk("in_data", link.in_data, e[159-8*i -: 8]);
            chk("in_last", link.in_last, i == 19);
            if (i < 19)
                @(negedge clk_sys);
        end
        for (i = 0; i < 12 && rec_done !== 1'b1; i++)
            @(negedge clk_sys);
        chk("cycle_busy", cycle_busy, 1'b0);
        for (i = 0; i < 4; i++) begin
            chk("rec_out", rec_out[i], e[159-40*i -: 40]);
            if (!poke)
                chk("disp_status", disp_status[i], e[127-40*i -: 8]);
        end
    endtask
    task t_frame;
        nxt[0] = {32'h40F0_0000, 8'h80};
        nxt[1] = {32'hC2C8_0001, 8'h4C};
        nxt[2] = {32'h0000_0000, 8'h0C};
        nxt[3] = {32'h7F80_1234, 8'h1F};
        load();
        go();
        frame({nxt[0], nxt[1], nxt[2], nxt[3]}, 1'b0);
    endtask
    // Update and start while busy: frame keeps its snapshot
    task t_refuse;
        int i;
        int n;
        logic [159:0] old;
        old = {nxt[0], nxt[1], nxt[2], nxt[3]};
        for (i = 0; i < 4; i++)
            nxt[i] = ~nxt[i];
        go();
        // Inputs change and a start is refused while the frame runs
        fork
            frame(old, 1'b1);
            begin
                repeat (4) @(posedge clk_sys);
                load();
                @(posedge clk_sys);
                cycle_go <= 1'b1;
                @(posedge clk_sys);
                cycle_go <= 1'b0;
            end
        join
        n = 0;
        for (i = 0; i < 12; i++) begin
            @(negedge clk_sys);
            n += (link.in_valid === 1'b1);
        end
        chk("extra_frame", n, 0);
        go();
        frame({nxt[0], nxt[1], nxt[2], nxt[3]}, 1'b0);
    endtask
    task send(input logic [63:0] v);
        @(posedge clk_sys);
        for (k = 0; k < 8; k++)
            out_bytes[k] <= v[63-8*k -: 8];
        out_go <= 1'b1;
        @(posedge clk_sys);
        out_go <= 1'b0;
        @(negedge clk_sys);
        for (k = 0; k < 30 && out_busy !== 1'b0; k++)
            @(negedge clk_sys);
        repeat (4) @(negedge clk_sys);
    endtask
    task t_out;
        send(64'h0103_4120_0000_8002);
        chk("tot_set", tot_set, 8'h01);
        chk("tot_hold", {tot_mode, tot_hold}, 9'h007);
        chk("disp_value", disp_value, 32'h4120_0000);
        chk("disp_stat", disp_value_stat, 8'h80);
        chk("ctrl_cmd", ctrl_cmd, 8'h02);
        chk("pulses", {n_rst[7:0], n_ctrl[7:0]}, 16'h0101);
        send(64'h0100_0000_0000_0000);
        chk("tot_hold", tot_hold, 1'b0);
        chk("pulses", {n_rst[7:0], n_ctrl[7:0]}, 16'h0101);
        send(64'h0000_0000_0000_0009);
        send(64'h0100_0000_0000_0009);
        chk("pulses", {n_rst[7:0], n_ctrl[7:0]}, 16'h0202);
    endtask
    // Stop a hung run
    initial begin
        repeat (5000) @(posedge clk_sys);
        error_cnt++;
        end_sim();
    end
    // Main sequence
    initial begin
        rst = 1'b1;
        cycle_go = 1'b0;
        meas_upd = 4'h0;
        out_go = 1'b0;
        for (k = 0; k < 8; k++)
            out_bytes[k] = 8'h00;
        for (k = 0; k < 4; k++)
            meas[k] = '0;
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        t_frame();
        t_refuse();
        t_out();
        end_sim();
    end
endmodule
